// [hdl/nvs_host.sv]
// Host controller driving a nonvolatile SRAM over its asynchronous pins.
// Assumes the device pins are wired directly; store_busy_line is open drain
// with an external pull-up resolved by the surroundings.
// What this block does
// - Write: CE, WE low, address held stable.
// - Host keeps OE high during writes.
// - Hardware save request pulse at least 15 ns.
// - Commands are six reads, WE high.
// - Five fixed addresses open every command.
// - Command sequences use reads only, OE active.
// - Auto save setting kept by manual save; this block issues none after mode commands.
module nvs_host #(
    parameter int SAVE_WAIT  = nvs_pkg::WAIT_SAVE_CLK,  // Save lockout cycles
    parameter int GRACE_WAIT = nvs_pkg::GRACE_CLK,      // Hardware grace cycles
    parameter int RCL_WAIT   = nvs_pkg::WAIT_RCL_CLK,   // Restore lockout cycles
    parameter int SS_WAIT    = nvs_pkg::WAIT_SS_CLK     // Mode command cycles
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    input  wire nvs_pkg::nvs_req_s       req,
    output logic                         req_ready,
    input  wire nvs_pkg::nvs_op_e        op,
    output logic                         op_ready,
    output logic [nvs_pkg::DATA_W-1:0]   rdata,
    output logic                         rvalid,
    output logic                         busy,
    output nvs_pkg::nvs_bus_s            bus,
    input  wire logic [nvs_pkg::DATA_W-1:0] dq_in,
    output logic [nvs_pkg::DATA_W-1:0]   dq_out,
    output logic                         dq_oe,
    input  wire logic                    store_busy_line_in,
    output logic                         store_busy_line_out,
    output logic                         store_busy_line_oe
);
    import nvs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nvs_state_e         state_ff, nxt_state;        // Bus sequencer
    nvs_bus_s           bus_ff, nxt_bus;            // Pin drive
    logic [DATA_W-1:0]  wdata_ff, nxt_wdata;        // Write data on pins
    logic               dq_oe_ff, nxt_dq_oe;        // Data drive enable
    logic [DATA_W-1:0]  rdata_ff, nxt_rdata;        // Captured read data
    logic               rvalid_ff, nxt_rvalid;      // Read answer pulse
    logic               write_ff, nxt_write;        // Current cycle kind
    logic [2:0]         step_ff, nxt_step;          // Command read index
    nvs_op_e            op_ff, nxt_op;              // Command in flight
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;            // Phase timer
    logic               hsb_drv_ff, nxt_hsb_drv;    // Pulling busy line
    logic [1:0]         hsb_sync_ff;                // Busy line synchroniser

    // Sixth address per command
    function automatic logic [ADDR_W-1:0] last_addr(input nvs_op_e o);
        unique case (o)
            SAVE:    last_addr = CMD_SAVE;
            RESTORE: last_addr = CMD_RESTORE;
            AS_OFF:  last_addr = CMD_AS_OFF;
            default: last_addr = CMD_AS_ON;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvs_op_e o);
        unique case (s)
            3'h0:    seq_addr = SEQ_A0;
            3'h1:    seq_addr = SEQ_A1;
            3'h2:    seq_addr = SEQ_A2;
            3'h3:    seq_addr = SEQ_A3;
            3'h4:    seq_addr = SEQ_A4;
            default: seq_addr = last_addr(o);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Device sees busy line low during its own saves; hold off then too
    assign busy      = (state_ff != ST_IDLE) || !hsb_sync_ff[1];
    assign req_ready = (state_ff == ST_IDLE) && hsb_sync_ff[1];
    assign op_ready  = req_ready;
    assign rdata     = rdata_ff;
    assign rvalid    = rvalid_ff;
    assign bus       = bus_ff;
    assign dq_out    = wdata_ff;
    assign dq_oe     = dq_oe_ff;
    // pull low only, never drive high
    assign store_busy_line_out = 1'b0;
    assign store_busy_line_oe  = hsb_drv_ff;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_bus     = bus_ff;
        nxt_wdata   = wdata_ff;
        nxt_dq_oe   = dq_oe_ff;
        nxt_rdata   = rdata_ff;
        nxt_rvalid  = 1'b0;
        nxt_write   = write_ff;
        nxt_step    = step_ff;
        nxt_op      = op_ff;
        nxt_cnt     = cnt_ff;
        nxt_hsb_drv = hsb_drv_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // Commands win over plain accesses when both arrive
                if (hsb_sync_ff[1] && op != NONE) begin
                    // mode commands persist only after a later save
                    nxt_op = op;
                    if (op == HW_SAVE) begin
                        nxt_hsb_drv = 1'b1;
                        nxt_cnt     = CNT_W'(HSB_PULSE_CLK);
                        nxt_state   = ST_HSB;
                    end else begin
                        nxt_write   = 1'b0;
                        nxt_step    = 3'h0;
                        nxt_bus.addr = seq_addr(3'h0, op);
                        nxt_cnt     = CNT_W'(1);
                        nxt_state   = ST_SETUP;
                    end
                end else if (hsb_sync_ff[1] && req.valid) begin
                    nxt_op       = NONE;
                    nxt_write    = req.write;
                    nxt_bus.addr = req.addr;
                    nxt_wdata    = req.wdata;
                    nxt_cnt      = CNT_W'(1);
                    nxt_state    = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address settles a cycle before strobes fall
                nxt_bus.ce_n = 1'b0;
                // command steps use reads, OE active
                if (write_ff) begin
                    nxt_bus.we_n = 1'b0;
                    nxt_dq_oe    = 1'b1;
                end else begin
                    nxt_bus.oe_n = 1'b0;
                end
                nxt_cnt   = CNT_W'(CYC_CLK);
                nxt_state = ST_STRB;
            end
            ST_STRB: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    if (!write_ff) begin
                        nxt_rdata = dq_in;
                    end
                    nxt_bus.ce_n = 1'b1;
                    nxt_bus.we_n = 1'b1;
                    nxt_bus.oe_n = 1'b1;
                    nxt_state    = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Address and data held one cycle past the strobe edge
                nxt_dq_oe = 1'b0;
                if (op_ff == NONE) begin
                    nxt_rvalid = !write_ff;
                    nxt_state  = ST_IDLE;
                end else if (step_ff != 3'(CMD_LEN - 1)) begin
                    // full address driven, device checks low bits
                    nxt_step     = step_ff + 3'h1;
                    nxt_bus.addr = seq_addr(step_ff + 3'h1, op_ff);
                    nxt_state    = ST_SETUP;
                end else begin
                    unique case (op_ff)
                        SAVE:    nxt_cnt = CNT_W'(SAVE_WAIT);
                        RESTORE: nxt_cnt = CNT_W'(RCL_WAIT);
                        default: nxt_cnt = CNT_W'(SS_WAIT);
                    endcase
                    nxt_state = ST_WAIT;
                end
            end
            ST_HSB: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    // let grace delay pass before waiting
                    nxt_hsb_drv = 1'b0;
                    nxt_cnt     = CNT_W'(GRACE_WAIT);
                    nxt_state   = ST_GRACE;
                end
            end
            ST_GRACE: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    nxt_cnt   = CNT_W'(SAVE_WAIT);
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // busy line high ends a hardware save early
                // no access while device lies busy
                if (cnt_ff > CNT_W'(1) && !(op_ff == HW_SAVE && hsb_sync_ff[1])) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // strobes already high, next write starts on an edge
                nxt_op    = NONE;
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_IDLE;
            bus_ff      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
            wdata_ff    <= '0;
            dq_oe_ff    <= 1'b0;
            rdata_ff    <= '0;
            rvalid_ff   <= 1'b0;
            write_ff    <= 1'b0;
            step_ff     <= 3'h0;
            op_ff       <= NONE;
            cnt_ff      <= '0;
            hsb_drv_ff  <= 1'b0;
            hsb_sync_ff <= 2'h3;
        end else if (clk_en) begin
            state_ff    <= nxt_state;
            bus_ff      <= nxt_bus;
            wdata_ff    <= nxt_wdata;
            dq_oe_ff    <= nxt_dq_oe;
            rdata_ff    <= nxt_rdata;
            rvalid_ff   <= nxt_rvalid;
            write_ff    <= nxt_write;
            step_ff     <= nxt_step;
            op_ff       <= nxt_op;
            cnt_ff      <= nxt_cnt;
            hsb_drv_ff  <= nxt_hsb_drv;
            hsb_sync_ff <= {hsb_sync_ff[0], store_busy_line_in};
        end
    end
endmodule

// [hdl/nvs_pkg.sv]
// Constants, types and timing counts for the host-side controller of a
// battery-free nonvolatile SRAM. Assumes a 100 MHz mclk.
package nvs_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;               // Address pins
    localparam int DATA_W = 8;                // Data pins
    localparam int CMD_LEN = 6;               // Reads per software command

    // ------------------------------------------------------------------
    // Software command addresses (low 16 bits compared by the device)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEQ_A0 = 17'h04e38;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 17'h0b1c7;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 17'h083e0;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 17'h07c1f;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 17'h0703f;
    localparam logic [ADDR_W-1:0] CMD_SAVE    = 17'h08fc0;
    localparam logic [ADDR_W-1:0] CMD_RESTORE = 17'h04c63;
    localparam logic [ADDR_W-1:0] CMD_AS_OFF  = 17'h08b45;
    localparam logic [ADDR_W-1:0] CMD_AS_ON   = 17'h04b46;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS        = 10;        // mclk period
    localparam int CYC_NS        = 45;        // Slowest speed grade cycle
    localparam int CYC_CLK       = (CYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HSB_PULSE_NS  = 15;        // Least hardware save pulse
    localparam int HSB_PULSE_CLK = (HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GRACE_US      = 70;        // Longest grace before save
    localparam int SAVE_MS       = 15;        // Longest save, industrial
    localparam int RESTORE_US    = 50;        // Longest software restore
    localparam int SS_US         = 70;        // Soft sequence processing
    localparam int WAIT_SAVE_CLK = SAVE_MS * 1000000 / CLK_NS;
    localparam int WAIT_RCL_CLK  = (RESTORE_US + SS_US) * 1000 / CLK_NS;
    localparam int WAIT_SS_CLK   = SS_US * 1000 / CLK_NS;
    localparam int GRACE_CLK     = GRACE_US * 1000 / CLK_NS;
    localparam int CNT_W         = 24;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        NONE    = 4'h0,
        SAVE    = 4'h1,
        RESTORE = 4'h2,
        AS_OFF  = 4'h3,
        AS_ON   = 4'h4,
        HW_SAVE = 4'h5
    } nvs_op_e;

    typedef struct packed {
        logic              valid;             // Request strobe
        logic              write;             // 1 write, 0 read
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvs_req_s;

    typedef struct packed {
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
    } nvs_bus_s;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_SETUP = 8'h02,
        ST_STRB  = 8'h04,
        ST_HOLD  = 8'h08,
        ST_HSB   = 8'h10,
        ST_GRACE = 8'h20,
        ST_WAIT  = 8'h40,
        ST_DONE  = 8'h80
    } nvs_state_e;
endpackage

// [verif/nvs_dev_model.sv]
// Behavioural model of the nonvolatile memory as seen from its pins.
// Assumes the bench resolves the data bus and the pulled-up busy line.
module nvs_dev_model #(
    parameter int SAVE_NS  = 150, // Save length, kept below host lockout
    parameter int RCL_NS   = 100, // Restore length
    parameter int GRACE_NS = 30   // Bus grace before a hardware save
) (
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  dq,
    input  wire logic        busy_line,
    output logic [7:0]       dq_drv,
    output logic             dq_drv_oe,
    output logic             pull,
    output logic [7:0]       saves,
    output logic             auto_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import nvs_pkg::*;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  mem [logic [16:0]];                // Volatile cells
    logic [7:0]  nv  [logic [16:0]];                // Nonvolatile copy
    logic        lock  = 1'b0;                      // Bus ignored
    logic        dirty = 1'b0;                      // Written since save
    logic        wr_ok = 1'b0;                      // Write began legally
    int          step  = 0;                         // Detector position
    logic [15:0] seq [5] = '{SEQ_A0[15:0], SEQ_A1[15:0], SEQ_A2[15:0], SEQ_A3[15:0], SEQ_A4[15:0]};
    initial begin
        pull = 1'b0;
        saves = 8'h00;
        auto_en = 1'b1;
    end
    task automatic run_save();
        lock = 1'b1;
        pull = 1'b1;
        #(SAVE_NS);
        nv = mem;
        dirty = 1'b0;
        saves = saves + 8'h01;
        pull = 1'b0;
        lock = 1'b0;
    endtask
    // supply dip: automatic save if enabled and dirty, restore on return
    task automatic supply_dip();
        lock = 1'b1;
        if (auto_en && dirty) run_save();
        lock = 1'b1;
        mem.delete();
        #(RCL_NS);
        mem = nv;
        dirty = 1'b0;
        lock = 1'b0;
    endtask
    always @* begin
        dq_drv_oe = !ce_n && !oe_n && we_n && busy_line && !lock;
        dq_drv = mem.exists(addr) ? mem[addr] : 8'h00;
    end
    // write needs a falling strobe, line high
    always @(negedge (ce_n | we_n)) wr_ok = busy_line && !lock;
    // store at the first rising strobe
    always @(posedge (ce_n | we_n)) begin
        if (wr_ok && !lock) begin
            mem[addr] = dq;
            dirty = 1'b1;
        end
        wr_ok = 1'b0;
        step = 0;
    end
    always @(negedge (ce_n | oe_n)) begin
        if (we_n && !lock) begin
            if (step == 5) begin
                step = 0;
                case (addr[15:0])
                    CMD_AS_OFF[15:0]: auto_en = 1'b0;
                    CMD_AS_ON[15:0]: auto_en = 1'b1;
                    CMD_SAVE[15:0]: run_save();
                    CMD_RESTORE[15:0]: begin
                        lock = 1'b1;
                        mem.delete();
                        #(RCL_NS);
                        mem = nv;
                        dirty = 1'b0;
                        lock = 1'b0;
                    end
                    default: ;
                endcase
            end else begin
                step = (addr[15:0] == seq[step]) ? step + 1 : int'(addr[15:0] == seq[0]);
            end
        end
    end
    always @(negedge busy_line) begin
        if (!pull) begin
            #(GRACE_NS);
            if (dirty) run_save();
        end
    end
endmodule

// [verif/nvs_host_chk.sv]
// Concurrent checks on the host controller's ports.
// Assumes clk_en is held high, so strobe counts are in mclk cycles.
module nvs_host_chk (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              req_ready,
    input wire logic              rvalid,
    input wire logic              busy,
    input wire nvs_pkg::nvs_bus_s bus,
    input wire logic              dq_oe,
    input wire logic              store_busy_line_in,
    input wire logic              store_busy_line_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import nvs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    rd_capture_a: assert property (rvalid |->
        $past(bus.oe_n) && !$past(bus.oe_n, 2) && $past(bus.we_n, 2))
        else $error("read data flagged without a finished read strobe");
    strobe_width_a: assert property ($fell(bus.ce_n) |-> !bus.ce_n [*5] ##1 bus.ce_n)
        else $error("chip enable low for other than five cycles");
    addr_hold_a: assert property (!bus.ce_n && !$past(bus.ce_n) |-> $stable(bus.addr))
        else $error("address moved while selected");
    wr_quiet_a: assert property (!bus.we_n |-> bus.oe_n && dq_oe)
        else $error("write without data drive or with output enable low");
    rd_clean_a: assert property (!bus.oe_n |-> !dq_oe && bus.we_n)
        else $error("read with host driving data or write enable low");
    ready_idle_a: assert property (req_ready |-> !busy && bus.ce_n && !store_busy_line_oe)
        else $error("ready while busy or in the middle of a cycle");
    pulse_len_a: assert property ($rose(store_busy_line_oe) |->
        store_busy_line_oe [*2] ##1 !store_busy_line_oe)
        else $error("hardware save pulse not two cycles");
    line_low_a: assert property (!store_busy_line_in [*3] |-> busy && !req_ready)
        else $error("new access offered while busy line low");
    rd_cov: cover property (rvalid);
    wr_cov: cover property ($fell(bus.we_n));
    hw_cov: cover property ($rose(store_busy_line_oe));
endmodule

// [verif/nvs_host_tb_top.sv]
// Self-checking bench: host controller against a behavioural memory.
// Assumes shortened lockout counts; the model finishes well inside them.
bind nvs_host nvs_host_chk u_chk (.mclk(mclk), .rst(rst), .req_ready(req_ready), .rvalid(rvalid),
    .busy(busy), .bus(bus), .dq_oe(dq_oe), .store_busy_line_in(store_busy_line_in),
    .store_busy_line_oe(store_busy_line_oe));
module nvs_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvs_pkg::*;
    logic       mclk = 1'b0, rst = 1'b1;
    nvs_req_s   req = '0;
    nvs_op_e    op = NONE;
    nvs_bus_s   bus;
    logic       req_ready, op_ready, rvalid, busy, dq_oe, d_oe, hsb_oe, hsb_out, d_pull, m_auto;
    logic [7:0] rdata, dq_out, d_dq, m_saves;
    logic [7:0] shadow [logic [16:0]];      // Expected array contents
    int         failures = 0, checked = 0;
    // Released lines show a pattern that flips each half cycle, not old data
    wire [7:0]  dq_in = dq_oe ? dq_out : d_oe ? d_dq : (8'ha5 ^ {8{mclk}});
    wire        store_busy_line = (hsb_oe ? hsb_out : 1'b1) && !d_pull;  // Pulled-up busy line
    always #5 mclk = ~mclk;
    nvs_host #(.SAVE_WAIT(20), .GRACE_WAIT(20), .RCL_WAIT(20), .SS_WAIT(20)) u_nvs_host (
        .mclk(mclk), .rst(rst), .clk_en(1'b1), .req(req), .req_ready(req_ready), .op(op),
        .op_ready(op_ready), .rdata(rdata), .rvalid(rvalid), .busy(busy), .bus(bus), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .store_busy_line_in(store_busy_line), .store_busy_line_out(hsb_out),
        .store_busy_line_oe(hsb_oe));
    nvs_dev_model u_nvs_dev_model (.ce_n(bus.ce_n), .we_n(bus.we_n), .oe_n(bus.oe_n), .addr(bus.addr),
        .dq(dq_in), .busy_line(store_busy_line), .dq_drv(d_dq), .dq_drv_oe(d_oe), .pull(d_pull), .saves(m_saves),
        .auto_en(m_auto));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [16:0] a);
        return shadow.exists(a) ? shadow[a] : 8'h00;
    endfunction
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t ns: %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One bus transfer; valid held until taken, then wait for rvalid or idle
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        req = '{1'b1, w, a, d};
        for (n = 0; n < 200 && !req_ready; n++) @(posedge mclk) #1;
        @(posedge mclk) #1;
        req.valid = 1'b0;
        for (n = 0; n < 20 && (w ? !req_ready : !rvalid); n++) @(posedge mclk) #1;
        q = rdata;
    endtask
    task automatic cmd(input nvs_op_e o);
        int n;
        op = o;
        for (n = 0; n < 200 && !op_ready; n++) @(posedge mclk) #1;
        @(posedge mclk) #1;
        op = NONE;
        for (n = 0; n < 400 && busy; n++) @(posedge mclk) #1;
        chk(busy === 1'b0, "operation did not finish");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [16:0] a, seq [6];
        logic [7:0]  d, q, s0;
        seq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, CMD_AS_OFF};
        void'($urandom(53));
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        // Random writes, both address ends included, then read back
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($urandom);
            d = 8'($urandom);
            xfer(1'b1, a, d, q);
            shadow[a] = d;
        end
        foreach (shadow[k]) begin
            xfer(1'b0, k, 8'h00, q);
            chk(q === exp_rd(k), "read data");
        end
        // Software save runs even with nothing new written
        s0 = m_saves;
        cmd(SAVE);
        cmd(SAVE);
        chk(m_saves === s0 + 8'h02, "software save count");
        // Overwrite, restore, expect the saved byte back
        a = 17'h1ffff;
        xfer(1'b1, a, ~exp_rd(a), q);
        cmd(RESTORE);
        xfer(1'b0, a, 8'h00, q);
        chk(q === exp_rd(a), "restored data");
        // Hardware save skipped while clean, taken once dirty
        s0 = m_saves;
        cmd(HW_SAVE);
        chk(m_saves === s0, "clean hardware save ran");
        xfer(1'b1, 17'h00000, 8'h5a, q);
        shadow[17'h00000] = 8'h5a;
        cmd(HW_SAVE);
        chk(m_saves === s0 + 8'h01, "dirty hardware save missing");
        // Automatic-save modes by command
        cmd(AS_OFF);
        chk(m_auto === 1'b0, "auto save still on");
        cmd(AS_ON);
        chk(m_auto === 1'b1, "auto save still off");
        // Raw sequence with the top address bit set still decodes
        for (int i = 0; i < 6; i++) xfer(1'b0, seq[i] | 17'h10000, 8'h00, q);
        chk(m_auto === 1'b0, "top bit broke the sequence");
        // A write mid-sequence restarts the detector
        seq[5] = CMD_AS_ON;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) xfer(1'b1, 17'h00100, 8'h3c, q);
            xfer(1'b0, seq[i], 8'h00, q);
        end
        shadow[17'h00100] = 8'h3c;
        chk(m_auto === 1'b0, "broken sequence acted");
        xfer(1'b0, 17'h00100, 8'h00, q);
        chk(q === exp_rd(17'h00100), "data after broken sequence");
        // Supply dip: no automatic save while disabled, one once enabled
        s0 = m_saves;
        u_nvs_dev_model.supply_dip();
        chk(m_saves === s0, "automatic save while disabled");
        cmd(AS_ON);
        xfer(1'b1, 17'h00200, 8'hc3, q);
        shadow[17'h00200] = 8'hc3;
        u_nvs_dev_model.supply_dip();
        chk(m_saves === s0 + 8'h01, "automatic save missing");
        xfer(1'b0, 17'h00200, 8'h00, q);
        chk(q === exp_rd(17'h00200), "data lost over supply dip");
        tally_and_finish();
    end
    // Watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
